// ### common/see_cfg.svh
`ifndef SEE_CFG_SVH
`define SEE_CFG_SVH

// ==========================================================
// Register map (byte addresses on APB)
`define SEE_REG_STATUS 8'h00
`define SEE_REG_CONFIG 8'h04

// ==========================================================
// Config register fields and reset value
`define SEE_CFG_EN_BIT 0
`define SEE_CFG_PROT_LSB 1
`define SEE_CFG_RESET 32'h0000_0001

// ==========================================================
// Status register fields
`define SEE_ST_BUSY_BIT 0
`define SEE_ST_PERMIT_BIT 1
`define SEE_ST_PROT_LSB 2
`define SEE_ST_FSM_LSB 4
`define SEE_ST_READ_BIT 6
`define SEE_ST_DEAD_BIT 7
`define SEE_ST_SEL_BIT 8
`define SEE_ST_HOLD_BIT 9

// ==========================================================
// Serial status byte, opcodes and pin sync slots
`define SEE_SR_TOP 4'hF
`define SEE_OP_PERMIT_SET 3'h6
`define SEE_OP_PERMIT_CLR 3'h4
`define SEE_OP_STATUS_READ 3'h5
`define SEE_OP_STATUS_UPDATE 3'h1
`define SEE_OP_ARRAY_READ 3'h3
`define SEE_OP_ARRAY_WRITE 3'h2
`define SEE_PIN_SCK 0
`define SEE_PIN_CS 1
`define SEE_PIN_DI 2
`define SEE_PIN_HOLD 3
`define SEE_PIN_WP 4

// ==========================================================
// Sizes and timing
`define SEE_DEPTH 512
`define SEE_AW_MAX 9
`define SEE_PAGE 16
`define SEE_TMR_W 20
`define SEE_CLK_MHZ 40
`define SEE_WRITE_TIME_US 5000
`define SEE_WRITE_CYC (`SEE_WRITE_TIME_US * `SEE_CLK_MHZ)

`endif

// ### common/see_pkg.sv
`include "see_cfg.svh"

package see_pkg;

	typedef enum logic [1:0] {
		SEE_IDLE = 2'b00,
		SEE_COPY = 2'b01,
		SEE_WAIT = 2'b10
	} see_state_e;

	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic [4:0] pv;
		logic sel;
		logic hold_act;
		logic dead;
		logic [2:0] bit_idx;
		logic [4:0] byte_cnt;
		logic [7:0] sr;
		logic [7:0] opc;
		logic [`SEE_AW_MAX-1:0] addr;
		logic [`SEE_AW_MAX-1:0] pg_base;
		logic [15:0] pg_vld;
		logic [7:0] out_sr;
		logic rd_act;
		logic started;
		logic miso;
		logic oe;
		logic wp_low;
		logic permit;
		logic [1:0] prot;
		logic [1:0] new_prot;
		logic is_sr;
		see_state_e st;
		logic [`SEE_TMR_W-1:0] timer;
		logic [3:0] copy_idx;
		logic enable;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} see_state_s;

endpackage : see_pkg

// ### verilog/see_front.sv
`timescale 1ns/10ps
`include "see_cfg.svh"

// Overview of operation
// [R1] Input bytes assembled most significant bit first
// [R2] First bit taken at first rise after select
// [R3] Output bytes shifted most significant bit first
// [R4] First output bit at first fall after instruction
// [R5] Output released while not selected
// [R6] Modes 0,0 and 1,1: rise in, fall out
// [R7] Master idles clock per mode
// [R8] Pause releases output, ignores clock and data
// [R9] Pause entered only while selected
// [R10] Pause starts and ends with clock low
// [R11] Pause keeps bit count and progress
// [R12] Deselect during pause abandons the instruction
// [R13] Program permit latch cleared at reset
// [R14] Write cycle needs select rise on byte boundary
// [R15] Array access ignored during programming cycle
// [R16] Invalid select and pause transitions ignored
// [R17] Select must rise right after last byte
// [R18] Reads, writes, status updates ignored while busy
// [R19] Protect size selects quarter, half or whole
// [R20] Array writes refused inside protected range
// [R21] No instruction before a select falling edge
// [R22] Ending reads never starts a write cycle
module see_front #(
	parameter int unsigned DEPTH = `SEE_DEPTH,
	parameter int unsigned WRITE_CYCLES = `SEE_WRITE_CYC
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Serial bus pins
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	input wire logic i_hold_n,
	input wire logic i_wp_n,
	output logic o_miso,
	output logic o_miso_oe
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [`SEE_TMR_W-1:0] TMR_LAST = `SEE_TMR_W'(WRITE_CYCLES - 1);

	// ==========================================================
	// Elaboration checks
	if (DEPTH < 128 || DEPTH > `SEE_DEPTH || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("DEPTH must be a power of two from 128 to 512");
	end
	if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << `SEE_TMR_W)) begin : g_bad_cycles
		$error("WRITE_CYCLES out of timer range");
	end

	// ==========================================================
	// Storage
	logic [7:0] mem [0:DEPTH-1];
	logic [7:0] pg [0:`SEE_PAGE-1];
	logic mem_we;
	logic [AW-1:0] mem_wa;
	logic [7:0] mem_wd;
	logic pg_we;
	logic [3:0] pg_wa;
	logic [7:0] pg_wd;

	see_pkg::see_state_s r;
	see_pkg::see_state_s n;

	// Upper quarter, upper half or whole array, scaled to the array size
	function automatic logic prot_hit(input logic [`SEE_AW_MAX-1:0] a, input logic [1:0] size);
		logic hit;
		hit = 1'b0;
		unique case (size)
			2'b00: hit = 1'b0;
			2'b01: hit = a[AW-1] & a[AW-2];
			2'b10: hit = a[AW-1];
			2'b11: hit = 1'b1;
		endcase
		return hit;
	endfunction : prot_hit

	function automatic logic [7:0] status_byte(input see_pkg::see_state_s s);
		return {`SEE_SR_TOP, s.prot, s.permit, s.st != see_pkg::SEE_IDLE};
	endfunction : status_byte

	// ==========================================================
	// Next state
	always_comb begin
		logic sck;
		logic sck_rise;
		logic sck_fall;
		logic cs_fall;
		logic cs_rise;
		logic busy;
		logic [7:0] b;
		logic [2:0] op;
		logic [`SEE_AW_MAX-1:0] ra;
		logic acc;
		logic set_permit;
		n = r;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = '0;
		pg_we = 1'b0;
		pg_wa = '0;
		pg_wd = '0;
		b = '0;
		ra = '0;
		op = r.opc[2:0];
		busy = r.st != see_pkg::SEE_IDLE;
		acc = i_psel & i_penable;
		set_permit = 1'b0;

		// Only the second sync stage and its delayed copy feed logic
		n.s1 = {i_wp_n, i_hold_n, i_mosi, i_cs_n, i_sclk};
		n.s2 = r.s1;
		n.pv = r.s2;
		sck = r.s2[`SEE_PIN_SCK];
		sck_rise = sck & ~r.pv[`SEE_PIN_SCK]; // R6
		sck_fall = ~sck & r.pv[`SEE_PIN_SCK]; // R6
		// Select is seen low at reset, so a select held low through reset never selects
		cs_fall = ~r.s2[`SEE_PIN_CS] & r.pv[`SEE_PIN_CS] & r.enable; // R21
		cs_rise = r.s2[`SEE_PIN_CS] & ~r.pv[`SEE_PIN_CS];

		// Write protect low drops the permit latch and spoils a pending update
		if (!r.s2[`SEE_PIN_WP]) begin
			n.permit = 1'b0;
			n.wp_low = 1'b1;
		end

		if (cs_fall) begin
			n.sel = 1'b1;
			n.hold_act = 1'b0;
			n.dead = 1'b0;
			n.bit_idx = '0; // R2
			n.byte_cnt = '0;
			n.rd_act = 1'b0;
			n.started = 1'b0;
			n.pg_vld = '0;
			n.wp_low = ~r.s2[`SEE_PIN_WP];
		end else if (r.sel && cs_rise) begin
			n.sel = 1'b0;
			n.rd_act = 1'b0; // R22
			// Abandoned when deselected in pause
			if (!r.hold_act && !r.dead) begin // R12
				if (r.bit_idx == 3'd0) begin // R14 R17
					unique case (op)
						`SEE_OP_PERMIT_SET: begin
							if (r.byte_cnt == 5'd1) begin
								n.permit = r.s2[`SEE_PIN_WP];
								set_permit = r.s2[`SEE_PIN_WP];
							end
						end
						`SEE_OP_PERMIT_CLR: if (r.byte_cnt == 5'd1) n.permit = 1'b0;
						`SEE_OP_STATUS_UPDATE: begin
							if (r.byte_cnt == 5'd2 && r.permit && !busy && !r.wp_low) begin // R18
								n.st = see_pkg::SEE_WAIT;
								n.is_sr = 1'b1;
								n.timer = '0;
							end
						end
						`SEE_OP_ARRAY_WRITE: begin
							if (r.byte_cnt >= 5'd3 && r.permit && !busy && !r.wp_low
								&& !prot_hit(r.pg_base, r.prot)) begin // R20
								n.st = see_pkg::SEE_COPY;
								n.is_sr = 1'b0;
								n.timer = '0;
								n.copy_idx = '0;
							end
						end
						default: n.st = r.st;
					endcase
				end
			end
		end else if (r.sel) begin
			// Pause follows its pin only while the clock is low
			if (!sck) begin
				n.hold_act = ~r.s2[`SEE_PIN_HOLD]; // R9 R10 R16
			end
			// Counters untouched in pause, so the transfer resumes in place
			if (!r.hold_act && !r.dead) begin // R8 R11
				if (sck_rise) begin
					b = {r.sr[6:0], r.s2[`SEE_PIN_DI]}; // R1
					n.sr = b;
					n.bit_idx = r.bit_idx + 3'd1;
					if (r.bit_idx == 3'd7) begin
						if (r.byte_cnt != 5'h1F) begin
							n.byte_cnt = r.byte_cnt + 5'd1;
						end
						if (r.byte_cnt == 5'd0) begin
							n.opc = b;
							if (b[7:4] != 4'h0 || b[2:0] == 3'h0 || b[2:0] == 3'h7) begin
								n.dead = 1'b1;
							end else if (b[2:0] == `SEE_OP_STATUS_READ) begin
								n.out_sr = status_byte(r);
								n.rd_act = 1'b1;
							end else if (busy && (b[2:0] == `SEE_OP_ARRAY_READ
								|| b[2:0] == `SEE_OP_ARRAY_WRITE || b[2:0] == `SEE_OP_STATUS_UPDATE)) begin
								n.dead = 1'b1; // R15 R18
							end
						end else begin
							unique case (op)
								`SEE_OP_STATUS_READ: n.out_sr = status_byte(r);
								`SEE_OP_STATUS_UPDATE: if (r.byte_cnt == 5'd1) n.new_prot = b[3:2];
								`SEE_OP_ARRAY_READ: begin
									ra = (r.byte_cnt == 5'd1) ? {r.opc[3], b} : r.addr;
									n.out_sr = mem[ra[AW-1:0]];
									n.addr = ra + `SEE_AW_MAX'(1);
									n.rd_act = 1'b1;
								end
								`SEE_OP_ARRAY_WRITE: begin
									if (r.byte_cnt == 5'd1) begin
										n.addr = {r.opc[3], b};
										n.pg_base = {r.opc[3], b};
									end else begin
										pg_we = 1'b1;
										pg_wa = r.addr[3:0];
										pg_wd = b;
										n.pg_vld[r.addr[3:0]] = 1'b1;
										// Address rolls over inside the page
										n.addr[3:0] = r.addr[3:0] + 4'd1;
									end
								end
								default: n.dead = 1'b1;
							endcase
						end
					end
				end
				if (sck_fall && r.rd_act) begin
					n.miso = r.out_sr[7]; // R3 R4
					n.out_sr = {r.out_sr[6:0], 1'b1};
					n.started = 1'b1;
				end
			end
		end

		n.oe = n.sel & n.rd_act & n.started & ~n.hold_act; // R5 R8

		// ======================================================
		// Self-timed write cycle
		unique case (r.st)
			see_pkg::SEE_IDLE: n.timer = r.timer;
			see_pkg::SEE_COPY: begin
				n.timer = r.timer + `SEE_TMR_W'(1);
				if (r.pg_vld[r.copy_idx]) begin
					mem_we = 1'b1;
					mem_wa = AW'({r.pg_base[`SEE_AW_MAX-1:4], r.copy_idx});
					mem_wd = pg[r.copy_idx];
				end
				n.copy_idx = r.copy_idx + 4'd1;
				if (r.copy_idx == 4'hF) begin
					n.st = see_pkg::SEE_WAIT;
				end
			end
			see_pkg::SEE_WAIT: begin
				n.timer = r.timer + `SEE_TMR_W'(1);
				if (r.timer >= TMR_LAST) begin
					n.st = see_pkg::SEE_IDLE;
					// A permit set landing in the same cycle wins over the end-of-cycle clear
					if (!set_permit) begin
						n.permit = 1'b0;
					end
					if (r.is_sr) begin
						n.prot = r.new_prot; // R19
					end
				end
			end
			default: n.st = see_pkg::SEE_IDLE;
		endcase

		// ======================================================
		// APB slave: one wait state, then pready for one cycle
		n.pready = acc & ~r.pready;
		if (!acc || r.pready) begin
			n.pslverr = 1'b0;
		end
		if (acc && !r.pready) begin
			n.prdata = '0;
			n.pslverr = 1'b0;
			unique case (i_paddr)
				`SEE_REG_STATUS: begin
					n.prdata[`SEE_ST_BUSY_BIT] = busy;
					n.prdata[`SEE_ST_PERMIT_BIT] = r.permit;
					n.prdata[`SEE_ST_PROT_LSB +: 2] = r.prot;
					n.prdata[`SEE_ST_FSM_LSB +: 2] = r.st;
					n.prdata[`SEE_ST_READ_BIT] = r.rd_act;
					n.prdata[`SEE_ST_DEAD_BIT] = r.dead;
					n.prdata[`SEE_ST_SEL_BIT] = r.sel;
					n.prdata[`SEE_ST_HOLD_BIT] = r.hold_act;
				end
				`SEE_REG_CONFIG: begin
					n.prdata[`SEE_CFG_EN_BIT] = r.enable;
					n.prdata[`SEE_CFG_PROT_LSB +: 2] = r.prot;
				end
				default: n.pslverr = 1'b1;
			endcase
		end
		if (acc && r.pready && i_pwrite && i_paddr == `SEE_REG_CONFIG) begin
			n.enable = i_pwdata[`SEE_CFG_EN_BIT];
			// Preloading the protect size during a cycle would race the update
			if (r.st == see_pkg::SEE_IDLE) begin
				n.prot = i_pwdata[`SEE_CFG_PROT_LSB +: 2];
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0; // R13
			r.enable <= 1'b1;
			r.miso <= 1'b1;
			r.st <= see_pkg::SEE_IDLE;
		end else begin
			r <= n;
		end
	end

	// Array and page buffer carry no reset
	always_ff @(posedge i_sys_clk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
		if (pg_we) begin
			pg[pg_wa] <= pg_wd;
		end
	end

	// ==========================================================
	// Outputs
	assign o_prdata = r.prdata;
	assign o_pready = r.pready;
	assign o_pslverr = r.pslverr;
	assign o_miso = r.miso;
	assign o_miso_oe = r.oe;

endmodule : see_front

// ### test/see_front_assertions.sv
`timescale 1ns/10ps
`include "see_cfg.svh"

module see_chk (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// APB
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	// Serial pins
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_hold_n,
	input wire logic o_miso,
	input wire logic o_miso_oe
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========================================================
	// Serial output; pins lag by the synchronisers, hence the slack
	a_oe_desel: assert property (i_cs_n [*5] |-> !o_miso_oe) else $error("output driven while deselected");
	a_oe_pause: assert property ((!i_hold_n && !i_sclk) [*6] |-> !o_miso_oe) else $error("output driven in pause");
	a_out_fall: assert property ($changed(o_miso) && o_miso_oe && $past(o_miso_oe)
		|-> !(i_sclk && $past(i_sclk) && $past(i_sclk, 2))) else $error("output moved off a falling edge");
	a_oe_first: assert property ($rose(o_miso_oe) |-> !(i_sclk && $past(i_sclk) && $past(i_sclk, 2)))
		else $error("output enabled off a falling edge");
	a_oe_sel: assert property ($rose(o_miso_oe) |-> !$past(i_cs_n, 3)) else $error("output enabled unselected");
	// ==========================================================
	// APB
	a_pready_wait: assert property (i_psel && i_penable && !$past(i_penable) |-> !o_pready ##1 o_pready)
		else $error("ready not after one wait state");
	a_pready_pulse: assert property (o_pready |=> !o_pready) else $error("ready longer than one cycle");
	a_err_map: assert property (o_pready |-> o_pslverr == (i_paddr != `SEE_REG_STATUS && i_paddr != `SEE_REG_CONFIG))
		else $error("error flag does not match the address");
	a_err_zero: assert property (o_pready && o_pslverr |-> o_prdata == 32'h0000_0000) else $error("error read not zero");
endmodule : see_chk

bind see_front see_chk u_chk (.i_sys_clk, .i_rst_n, .i_psel, .i_penable, .i_paddr, .o_prdata, .o_pready,
	.o_pslverr, .i_sclk, .i_cs_n, .i_hold_n, .o_miso, .o_miso_oe);

// ### test/see_spi_master.sv
`timescale 1ns/10ps

module see_spi_master (
	// Bench clock
	input wire logic i_clk,
	// Pins toward the device
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_mosi,
	output logic o_hold_n,
	// Device answer
	input wire logic i_miso,
	input wire logic i_miso_oe
);
	logic cpol = 1'b0;
	logic last = 1'b0;
	// ==========================================================
	// Link clock pulses only inside frames, mode sets its idle level between them; a half period is four bench clocks
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
		o_hold_n = 1'b1;
	end
	task mode(input logic m);
		@(posedge i_clk);
		cpol <= m;
		o_sclk <= m;
		repeat (16) @(posedge i_clk);
	endtask : mode
	task sel;
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		repeat (8) @(posedge i_clk);
	endtask : sel
	task xf(input logic [7:0] t, input int n, output logic [7:0] x);
		x = 8'h00;
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			o_sclk <= 1'b0;
			o_mosi <= t[7 - i];
			repeat (4) @(posedge i_clk);
			o_sclk <= 1'b1;
			// Undriven line drifts, so a released output never reads as data
			last = i_miso_oe ? i_miso : ~last;
			x = {x[6:0], last};
			repeat (3) @(posedge i_clk);
		end
		@(posedge i_clk);
		o_sclk <= cpol;
	endtask : xf
	task desel;
		repeat (2) @(posedge i_clk);
		o_cs_n <= 1'b1;
		o_mosi <= ~o_mosi;
		repeat (16) @(posedge i_clk);
	endtask : desel
	task hl(input logic v);
		@(posedge i_clk);
		o_hold_n <= v;
		repeat (10) @(posedge i_clk);
	endtask : hl
endmodule : see_spi_master

// ### test/see_front_tb.sv
`timescale 1ns/10ps
`include "see_cfg.svh"
`define CK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t %h %h", $time, a, b); end end

module see_front_tb;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pw = 0, pready, perr, miso, oe, sclk, cs_n, mosi, hold_n, wp_n = 1;
	logic saw = 0, e;
	logic [7:0] pa = 0, b, b2;
	logic [31:0] pwd = 0, prd, r;
	int n_errors = 0, comparisons = 0, cyc = 0;

	see_front #(.WRITE_CYCLES(1000)) u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready), .o_pslverr(perr),
		.i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_miso(miso),
		.o_miso_oe(oe));
	see_spi_master u_m (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .o_hold_n(hold_n),
		.i_miso(miso), .i_miso_oe(oe));

	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (oe)
			saw <= 1;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	// ==========================================================
	// Shared tasks
	task tally_and_finish;
		$display("mismatches %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pen <= 0;
		pw <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prd;
		e = perr;
		psel <= 0;
		pen <= 0;
	endtask : apb
	task cmd(input logic [7:0] op);
		u_m.sel();
		u_m.xf(op, 8, b);
		u_m.desel();
	endtask : cmd
	task sr(input logic [7:0] x);
		u_m.sel();
		u_m.xf(8'h05, 8, b);
		u_m.xf(8'h00, 8, b);
		u_m.desel();
		`CK(b, x)
	endtask : sr
	task wb;
		repeat (400) begin
			apb(0, `SEE_REG_STATUS, 0);
			if (r[0] === 1'b0)
				break;
		end
		`CK(r[0], 1'b0)
	endtask : wb
	task wr3(input logic [7:0] op, input logic [7:0] ad, input logic [7:0] d);
		u_m.sel();
		u_m.xf(op, 8, b);
		u_m.xf(ad, 8, b);
		u_m.xf(d, 8, b);
		u_m.desel();
		apb(0, `SEE_REG_STATUS, 0);
	endtask : wr3
	// ==========================================================
	// Scenarios
	task t_apb;
		apb(0, `SEE_REG_CONFIG, 0);
		`CK(r, 32'h0000_0001)
		apb(1, `SEE_REG_STATUS, 32'hFFFF_FFFF);
		apb(0, `SEE_REG_STATUS, 0);
		`CK(r[1], 1'b0)
		apb(0, 8'h08, 0);
		`CK({e, r}, {1'b1, 32'h0000_0000})
		// Selects switched off and protect size preloaded: a status read must stay silent
		apb(1, `SEE_REG_CONFIG, 32'h0000_0002);
		apb(0, `SEE_REG_CONFIG, 0);
		`CK(r, 32'h0000_0002)
		saw = 0;
		u_m.sel();
		u_m.xf(8'h05, 8, b);
		u_m.xf(8'h00, 8, b);
		u_m.desel();
		`CK(saw, 1'b0)
		apb(1, `SEE_REG_CONFIG, 32'h0000_0001);
		apb(0, `SEE_REG_STATUS, 0);
		`CK(r[3:2], 2'b00)
	endtask : t_apb
	task t_modes;
		u_m.mode(1);
		sr(8'hF0);
		cmd(8'h06);
		sr(8'hF2);
		u_m.mode(0);
		sr(8'hF2);
		cmd(8'h04);
		sr(8'hF0);
	endtask : t_modes
	task t_hold;
		cmd(8'h06);
		u_m.sel();
		u_m.xf(8'h05, 8, b);
		u_m.xf(8'h00, 4, b);
		u_m.hl(0);
		u_m.xf(8'hFF, 3, b2);
		u_m.hl(1);
		u_m.xf(8'h00, 4, b2);
		u_m.desel();
		`CK({b[3:0], b2[3:0]}, 8'hF2)
		u_m.sel();
		u_m.xf(8'h04, 8, b);
		u_m.hl(0);
		u_m.desel();
		u_m.hl(1);
		sr(8'hF2);
	endtask : t_hold
	task t_upd;
		// Status update is the opcode and exactly one data byte
		u_m.sel();
		u_m.xf(8'h01, 8, b);
		u_m.xf(8'h04, 8, b);
		u_m.desel();
		sr(8'hF3);
		saw = 0;
		wr3(8'h03, 8'h00, 8'h00);
		`CK(saw, 1'b0)
		wb();
		sr(8'hF4);
		cmd(8'h06);
		u_m.sel();
		u_m.xf(8'h01, 8, b);
		u_m.xf(8'h0C, 8, b);
		u_m.xf(8'h00, 3, b);
		u_m.desel();
		apb(0, `SEE_REG_STATUS, 0);
		`CK(r[0], 1'b0)
		sr(8'hF6);
	endtask : t_upd
	task t_prot;
		wr3(8'h0A, 8'h80, 8'h5A);
		`CK(r[0], 1'b0)
		cmd(8'h06);
		wr3(8'h0A, 8'h7F, 8'hA5);
		`CK(r[0], 1'b1)
		wb();
		wr3(8'h0B, 8'h7F, 8'h00);
		`CK(b, 8'hA5)
		`CK(r[0], 1'b0)
	endtask : t_prot
	task t_wp;
		@(posedge clk);
		wp_n <= 1'b0;
		cmd(8'h06);
		sr(8'hF4);
		@(posedge clk);
		wp_n <= 1'b1;
		cmd(8'h06);
		sr(8'hF6);
	endtask : t_wp

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1;
		t_apb();
		t_modes();
		t_hold();
		t_upd();
		t_prot();
		t_wp();
		tally_and_finish();
	end
endmodule : see_front_tb
